/* File: src/srtmc_defs.vh */
// How it works
// - in external sample mode every strobe rising edge yields one baseband sample pulse
// - the sample pulse follows the strobe edge after the synchroniser delay
// - one cycle after the sample pulse the dump filters move into the matched filter
// - manual detect fires only with detect enable set and the OR of inputs rising
// - detect pin and software detect bit are ORed; rising OR triggers detect
// - second baseband pulse after a detect edge moves correlations to the demodulator
// - abort pin and software abort bit are ORed; rising OR triggers an abort
// - second baseband pulse after abort edge stops burst, clears burst counters
// - burst counters stay idle after abort until preamble or manual detect
// - in internal sample mode the baseband pulse comes from a programmable divider
// - low oscillator enable holds the oscillator in reset and drops its frequency word
// - oscillator enable pin ORed with software bit; fall resets it the next cycle
// - rising transmit enable starts one preamble symbol, then data symbols
// - transmit enable pin ORed with software bit; fall resets transmit path next cycle
// - rising receive enable puts the receiver into acquisition mode
// - receive enable pin ORed with software bit; fall starts a six cycle reset
// - receiver power-down clears the test output select, no other register
// - frequency word lands six edges after a load edge; repeats meanwhile are ignored
`ifndef SRTMC_DEFS_VH
`define SRTMC_DEFS_VH

// register indices, byte address is four times the index
`define SRTMC_IDX_FREQ_CMD   6'h00
`define SRTMC_IDX_SAMPLE_CFG 6'h01
`define SRTMC_IDX_DIVIDER    6'h02
`define SRTMC_IDX_FREQ_WORD  6'h10
`define SRTMC_IDX_DET_EN     6'h30
`define SRTMC_IDX_SW_DET     6'h31
`define SRTMC_IDX_SW_ABORT   6'h32
`define SRTMC_IDX_POWER      6'h37
`define SRTMC_IDX_TEST_SEL   6'h38
`define SRTMC_IDX_STATUS     6'h3f

// field positions
`define SRTMC_BIT_EXT_SAMPLE 0
`define SRTMC_BIT_OSC_EN     0
`define SRTMC_BIT_TX_EN      1
`define SRTMC_BIT_RX_EN      2
`define SRTMC_DIV_HI         5

// reset values and fixed codes
`define SRTMC_RST_BYTE       8'h00
`define SRTMC_RST_POWER      3'h0
`define SRTMC_DIV_RST        6'h01
`define SRTMC_TEST_SEL_MF    8'h00
`define SRTMC_TEST_SEL_STAT  8'h01
`define SRTMC_RD_PAD         24'h000000

// timing counts in IF clock cycles or baseband pulses
`define SRTMC_RX_RST_CYCLES  3'd6
`define SRTMC_FL_CYCLES      3'd6
`define SRTMC_BB_EDGES       2'd2

// synchronised pin slots
`define SRTMC_NPINS          7
`define SRTMC_PIN_SAMPLE     0
`define SRTMC_PIN_DET        1
`define SRTMC_PIN_ABORT      2
`define SRTMC_PIN_OSC        3
`define SRTMC_PIN_TX         4
`define SRTMC_PIN_RX         5
`define SRTMC_PIN_FLOAD      6

`endif

/* File: src/srtmc_pin_sync.v */
`timescale 1ns/1ps
`default_nettype none

module srtmc_pin_sync (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // pin and clean level
  input  wire pin,
  output reg  level
);

  reg ff1;
  reg ff2;
  reg ff3;

  // first stage feeds only the second; agreement of 2 and 3 filters glitches
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ff1   <= 1'b0;
      ff2   <= 1'b0;
      ff3   <= 1'b0;
      level <= 1'b0;
    end else begin
      ff1 <= pin;
      ff2 <= ff1;
      ff3 <= ff2;
      if (ff2 == ff3) begin
        level <= ff3;
      end
    end
  end

endmodule // srtmc_pin_sync

`default_nettype wire

/* File: src/srtmc_tick_delay.v */
`timescale 1ns/1ps
`include "srtmc_defs.vh"
`default_nettype none

module srtmc_tick_delay (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // event and baseband tick
  input  wire start,
  input  wire tick,
  output reg  done
);

  reg [1:0] cnt;

  // a new event restarts the wait; a tick in the same cycle is not counted
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt  <= 2'd0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt <= `SRTMC_BB_EDGES;
      end else if (tick && (cnt != 2'd0)) begin
        cnt <= cnt - 2'd1;
        done <= (cnt == 2'd1);
      end
    end
  end

endmodule // srtmc_tick_delay

`default_nettype wire

/* File: src/srtmc_top.v */
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "srtmc_defs.vh"
`default_nettype none

module srtmc_top (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // outside control pins
  input  wire        ext_baseband_sample_strobe,
  input  wire        ext_symbol_detect_strobe,
  input  wire        ext_burst_abort,
  input  wire        osc_enable_in,
  input  wire        tx_enable_in,
  input  wire        rx_enable_in,
  input  wire        freq_load_strobe,
  // datapath feedback
  input  wire        preamble_detect,
  input  wire        tx_symbol_end,
  input  wire [7:0]  mf_iq_in,
  // receive timing
  output reg         baseband_sample_pulse,
  output reg         if_dump_transfer,
  output wire        demod_transfer,
  output wire        burst_abort_pulse,
  output reg         counters_active,
  output reg         rx_acquire_mode,
  output reg         rx_enabled,
  output reg         rx_datapath_reset,
  // oscillator
  output reg         osc_reset,
  output reg  [7:0]  osc_freq_word,
  output reg         osc_word_loaded,
  // transmit
  output reg         tx_datapath_reset,
  output reg         tx_start,
  output reg         tx_preamble,
  output reg         tx_data_phase,
  // test bus
  output reg  [7:0]  test_output_bus
);

  localparam TX_IDLE     = 2'b00;
  localparam TX_PREAMBLE = 2'b01;
  localparam TX_DATA     = 2'b10;

  //////////////////////////////////////////////////////////////////////////////
  // control registers

  reg        freq_cmd;
  reg        ext_sample_mode;
  reg [5:0]  divider;
  reg [7:0]  freq_word;
  reg        det_enable;
  reg        sw_detect;
  reg        sw_abort;
  reg [2:0]  power_ctl;
  reg [7:0]  test_sel;

  //////////////////////////////////////////////////////////////////////////////
  // internal state

  reg [`SRTMC_NPINS-1:0] prev_eff;
  reg [5:0]              div_cnt;
  reg [2:0]              rx_rst_cnt;
  reg [2:0]              fl_cnt;
  reg [1:0]              tx_state;
  reg [1:0]              next_tx_state;
  reg [7:0]              next_rd;
  reg                    next_err;

  wire [`SRTMC_NPINS-1:0] pin_raw;
  wire [`SRTMC_NPINS-1:0] lvl;
  wire [`SRTMC_NPINS-1:0] eff;
  wire [`SRTMC_NPINS-1:0] rise;
  wire [`SRTMC_NPINS-1:0] fall;
  wire [5:0]              idx;
  wire                    setup;
  wire                    wr;
  wire                    div_tick;
  wire                    bb_tick;
  wire                    det_fire;
  wire                    fl_busy;
  wire [7:0]              status;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  assign pin_raw[`SRTMC_PIN_SAMPLE] = ext_baseband_sample_strobe;
  assign pin_raw[`SRTMC_PIN_DET]    = ext_symbol_detect_strobe;
  assign pin_raw[`SRTMC_PIN_ABORT]  = ext_burst_abort;
  assign pin_raw[`SRTMC_PIN_OSC]    = osc_enable_in;
  assign pin_raw[`SRTMC_PIN_TX]     = tx_enable_in;
  assign pin_raw[`SRTMC_PIN_RX]     = rx_enable_in;
  assign pin_raw[`SRTMC_PIN_FLOAD]  = freq_load_strobe;

  genvar gi;
  generate
    for (gi = 0; gi < `SRTMC_NPINS; gi = gi + 1) begin : g_sync
      srtmc_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (pin_raw[gi]),
        .level   (lvl[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // effective controls: pins except the sample strobe ORed with software bit, then edges

  assign eff[`SRTMC_PIN_SAMPLE] = lvl[`SRTMC_PIN_SAMPLE];
  assign eff[`SRTMC_PIN_DET]    = lvl[`SRTMC_PIN_DET] | sw_detect;
  assign eff[`SRTMC_PIN_ABORT]  = lvl[`SRTMC_PIN_ABORT] | sw_abort;
  assign eff[`SRTMC_PIN_OSC]    = lvl[`SRTMC_PIN_OSC] | power_ctl[`SRTMC_BIT_OSC_EN];
  assign eff[`SRTMC_PIN_TX]     = lvl[`SRTMC_PIN_TX] | power_ctl[`SRTMC_BIT_TX_EN];
  assign eff[`SRTMC_PIN_RX]     = lvl[`SRTMC_PIN_RX] | power_ctl[`SRTMC_BIT_RX_EN];
  assign eff[`SRTMC_PIN_FLOAD]  = lvl[`SRTMC_PIN_FLOAD] | freq_cmd;

  assign rise = eff & ~prev_eff;
  assign fall = ~eff & prev_eff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_eff <= {`SRTMC_NPINS{1'b0}};
    end else begin
      prev_eff <= eff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // baseband sample timing

  // divider period is value plus one; values below one are meaningless
  assign div_tick = (div_cnt == 6'h00);
  assign bb_tick  = ext_sample_mode ? rise[`SRTMC_PIN_SAMPLE] : div_tick;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt               <= 6'h00;
      baseband_sample_pulse <= 1'b0;
      if_dump_transfer      <= 1'b0;
    end else begin
      if (div_tick) begin
        div_cnt <= divider;
      end else begin
        div_cnt <= div_cnt - 6'h01;
      end
      baseband_sample_pulse <= bb_tick;
      if_dump_transfer      <= baseband_sample_pulse;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // manual detect and abort, counted in baseband pulses

  assign det_fire = det_enable & rise[`SRTMC_PIN_DET];

  srtmc_tick_delay u_det_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (det_fire),
    .tick    (baseband_sample_pulse),
    .done    (demod_transfer)
  );

  srtmc_tick_delay u_abort_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (rise[`SRTMC_PIN_ABORT]),
    .tick    (baseband_sample_pulse),
    .done    (burst_abort_pulse)
  );

  // reactivation beats the abort when both land together
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counters_active <= 1'b0;
      rx_acquire_mode <= 1'b1;
    end else begin
      if (preamble_detect || demod_transfer) begin
        counters_active <= 1'b1;
      end else if (burst_abort_pulse) begin
        counters_active <= 1'b0;
      end
      if (burst_abort_pulse || rise[`SRTMC_PIN_RX]) begin
        rx_acquire_mode <= 1'b1;
      end else if (preamble_detect) begin
        rx_acquire_mode <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // receiver power-down

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_enabled        <= 1'b0;
      rx_rst_cnt        <= 3'd0;
      rx_datapath_reset <= 1'b0;
    end else begin
      rx_enabled <= eff[`SRTMC_PIN_RX];
      if (fall[`SRTMC_PIN_RX]) begin
        rx_rst_cnt        <= `SRTMC_RX_RST_CYCLES - 3'd1;
        rx_datapath_reset <= 1'b1;
      end else if (rx_rst_cnt != 3'd0) begin
        rx_rst_cnt <= rx_rst_cnt - 3'd1;
      end else begin
        rx_datapath_reset <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // oscillator enable and frequency load

  assign fl_busy = (fl_cnt != 3'd0);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_reset       <= 1'b1;
      fl_cnt          <= 3'd0;
      osc_freq_word   <= `SRTMC_RST_BYTE;
      osc_word_loaded <= 1'b0;
    end else begin
      osc_reset <= ~eff[`SRTMC_PIN_OSC];
      if (!eff[`SRTMC_PIN_OSC]) begin
        // word is lost on power-down, software has to load it again
        fl_cnt          <= 3'd0;
        osc_freq_word   <= `SRTMC_RST_BYTE;
        osc_word_loaded <= 1'b0;
      end else if (rise[`SRTMC_PIN_FLOAD] && !fl_busy) begin
        fl_cnt <= `SRTMC_FL_CYCLES - 3'd1;
      end else if (fl_busy) begin
        fl_cnt <= fl_cnt - 3'd1;
        if (fl_cnt == 3'd1) begin
          osc_freq_word   <= freq_word;
          osc_word_loaded <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // transmit sequence

  always @* begin
    next_tx_state = tx_state;
    case (tx_state)
      TX_IDLE: begin
        if (rise[`SRTMC_PIN_TX]) begin
          next_tx_state = TX_PREAMBLE;
        end
      end
      TX_PREAMBLE: begin
        if (!eff[`SRTMC_PIN_TX]) begin
          next_tx_state = TX_IDLE;
        end else if (tx_symbol_end) begin
          next_tx_state = TX_DATA;
        end
      end
      TX_DATA: begin
        if (!eff[`SRTMC_PIN_TX]) begin
          next_tx_state = TX_IDLE;
        end
      end
      default: begin
        next_tx_state = TX_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state          <= TX_IDLE;
      tx_datapath_reset <= 1'b1;
      tx_start          <= 1'b0;
      tx_preamble       <= 1'b0;
      tx_data_phase     <= 1'b0;
    end else begin
      tx_state          <= next_tx_state;
      tx_datapath_reset <= ~eff[`SRTMC_PIN_TX];
      tx_start          <= rise[`SRTMC_PIN_TX];
      tx_preamble       <= (next_tx_state == TX_PREAMBLE);
      tx_data_phase     <= (next_tx_state == TX_DATA);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait-free access, answer prepared in the setup cycle

  assign idx   = paddr[7:2];
  assign setup = psel & ~penable;
  assign wr    = psel & penable & pready & pwrite & pstrb[0];

  assign status = {1'b0, fl_busy, osc_word_loaded, counters_active,
                   rx_acquire_mode, tx_state, rx_enabled};

  always @* begin
    next_rd  = `SRTMC_RST_BYTE;
    next_err = 1'b0;
    if (idx == `SRTMC_IDX_FREQ_CMD) begin
      next_rd = {7'h00, freq_cmd};
    end else if (idx == `SRTMC_IDX_SAMPLE_CFG) begin
      next_rd = {7'h00, ext_sample_mode};
    end else if (idx == `SRTMC_IDX_DIVIDER) begin
      next_rd = {2'h0, divider};
    end else if (idx == `SRTMC_IDX_FREQ_WORD) begin
      next_rd = freq_word;
    end else if (idx == `SRTMC_IDX_DET_EN) begin
      next_rd = {7'h00, det_enable};
    end else if (idx == `SRTMC_IDX_SW_DET) begin
      next_rd = {7'h00, sw_detect};
    end else if (idx == `SRTMC_IDX_SW_ABORT) begin
      next_rd = {7'h00, sw_abort};
    end else if (idx == `SRTMC_IDX_POWER) begin
      next_rd = {5'h00, power_ctl};
    end else if (idx == `SRTMC_IDX_TEST_SEL) begin
      next_rd = test_sel;
    end else if (idx == `SRTMC_IDX_STATUS) begin
      next_rd = status;
    end else begin
      next_err = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= {`SRTMC_RD_PAD, `SRTMC_RST_BYTE};
    end else begin
      pready <= setup;
      if (setup) begin
        pslverr <= next_err;
        prdata  <= {`SRTMC_RD_PAD, next_rd};
      end
    end
  end

  // register writes; receiver power-down clear of the test select wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      freq_cmd        <= 1'b0;
      ext_sample_mode <= 1'b0;
      divider         <= `SRTMC_DIV_RST;
      freq_word       <= `SRTMC_RST_BYTE;
      det_enable      <= 1'b0;
      sw_detect       <= 1'b0;
      sw_abort        <= 1'b0;
      power_ctl       <= `SRTMC_RST_POWER;
      test_sel        <= `SRTMC_TEST_SEL_MF;
    end else begin
      if (wr && (idx == `SRTMC_IDX_FREQ_CMD)) begin
        freq_cmd <= pwdata[0];
      end
      if (wr && (idx == `SRTMC_IDX_SAMPLE_CFG)) begin
        ext_sample_mode <= pwdata[`SRTMC_BIT_EXT_SAMPLE];
      end
      if (wr && (idx == `SRTMC_IDX_DIVIDER)) begin
        divider <= pwdata[`SRTMC_DIV_HI:0];
      end
      if (wr && (idx == `SRTMC_IDX_FREQ_WORD)) begin
        freq_word <= pwdata[7:0];
      end
      if (wr && (idx == `SRTMC_IDX_DET_EN)) begin
        det_enable <= pwdata[0];
      end
      if (wr && (idx == `SRTMC_IDX_SW_DET)) begin
        sw_detect <= pwdata[0];
      end
      if (wr && (idx == `SRTMC_IDX_SW_ABORT)) begin
        sw_abort <= pwdata[0];
      end
      if (wr && (idx == `SRTMC_IDX_POWER)) begin
        power_ctl <= pwdata[2:0];
      end
      if (fall[`SRTMC_PIN_RX]) begin
        test_sel <= `SRTMC_TEST_SEL_MF;
      end else if (wr && (idx == `SRTMC_IDX_TEST_SEL)) begin
        test_sel <= pwdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // test output bus, undefined selections read zero

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_output_bus <= `SRTMC_RST_BYTE;
    end else if (test_sel == `SRTMC_TEST_SEL_MF) begin
      test_output_bus <= mf_iq_in;
    end else if (test_sel == `SRTMC_TEST_SEL_STAT) begin
      test_output_bus <= status;
    end else begin
      test_output_bus <= `SRTMC_RST_BYTE;
    end
  end

endmodule // srtmc_top

`default_nettype wire

/* File: tb/srtmc_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module srtmc_top_monitor (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // watched ports
  input wire logic       preamble_detect,
  input wire logic       baseband_sample_pulse,
  input wire logic       if_dump_transfer,
  input wire logic       demod_transfer,
  input wire logic       burst_abort_pulse,
  input wire logic       counters_active,
  input wire logic       rx_acquire_mode,
  input wire logic       rx_enabled,
  input wire logic       rx_datapath_reset,
  input wire logic       osc_reset,
  input wire logic [7:0] osc_freq_word,
  input wire logic       osc_word_loaded,
  input wire logic       tx_datapath_reset,
  input wire logic       tx_start,
  input wire logic       tx_preamble,
  input wire logic       tx_data_phase
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  a_dump_after_sample: assert property (
    baseband_sample_pulse |=> if_dump_transfer) else $error("dump not after sample");
  a_sample_one_pulse: assert property (
    baseband_sample_pulse |=> !baseband_sample_pulse) else $error("sample pulse too long");
  a_rx_reset_six: assert property (
    $rose(rx_datapath_reset) |-> rx_datapath_reset[*6] ##1 !rx_datapath_reset)
    else $error("rx reset not six cycles");
  a_rx_enable_acq: assert property (
    $rose(rx_enabled) |-> ##[0:1] rx_acquire_mode) else $error("no acquisition on enable");
  a_tx_start_pre: assert property (
    tx_start |-> tx_preamble && !tx_datapath_reset) else $error("start without preamble");
  a_tx_reset_idle: assert property (
    tx_datapath_reset |-> !tx_preamble && !tx_data_phase) else $error("tx busy in reset");
  a_pre_then_data: assert property (
    $fell(tx_preamble) && !tx_datapath_reset |-> tx_data_phase)
    else $error("no data after preamble");
  a_abort_clears: assert property (
    burst_abort_pulse && !preamble_detect && !demod_transfer
    |-> ##[0:1] (!counters_active && rx_acquire_mode)) else $error("abort left counters");
  // reactivation may lag its cause by one cycle
  a_counters_idle: assert property (
    !counters_active && !preamble_detect && !demod_transfer
    && !$past(preamble_detect) && !$past(demod_transfer) |=> !counters_active)
    else $error("counters woke alone");
  a_osc_held: assert property (
    osc_reset |-> osc_freq_word == 8'h00 && !osc_word_loaded) else $error("osc word kept");

  c_demod: cover property (demod_transfer);
  c_abort: cover property (burst_abort_pulse);
  c_tx: cover property (tx_start);
  c_rx_off: cover property ($fell(rx_datapath_reset));
endmodule // srtmc_top_monitor

bind srtmc_top srtmc_top_monitor u_mon (.pclk, .presetn, .preamble_detect,
  .baseband_sample_pulse, .if_dump_transfer, .demod_transfer, .burst_abort_pulse,
  .counters_active, .rx_acquire_mode, .rx_enabled, .rx_datapath_reset, .osc_reset,
  .osc_freq_word, .osc_word_loaded, .tx_datapath_reset, .tx_start, .tx_preamble,
  .tx_data_phase);

`default_nettype wire

/* File: tb/srtmc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module srtmc_host_model (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // bench command and device status
  input  wire logic strobe_on,
  input  wire logic tx_preamble,
  // pins toward the device
  output var  logic ext_baseband_sample_strobe,
  output var  logic tx_symbol_end
);
  logic [2:0] phase;
  logic       run;
  logic [2:0] sym_cnt;

  ////////////////////////////////////////////////////////////////////////////
  // eight clock period, start only at phase 0 so no runt pulse reaches the filter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= 3'h0;
      run <= 1'b0;
      ext_baseband_sample_strobe <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      if (phase == 3'h0) begin
        run <= strobe_on;
      end
      ext_baseband_sample_strobe <= run & phase[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // preamble symbol ends a few clocks after it starts
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_cnt <= 3'h0;
      tx_symbol_end <= 1'b0;
    end else begin
      sym_cnt <= tx_preamble ? sym_cnt + 3'h1 : 3'h0;
      tx_symbol_end <= tx_preamble && sym_cnt == 3'h4;
    end
  end
endmodule // srtmc_host_model

`default_nettype wire

/* File: tb/srtmc_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module srtmc_top_tb_top;
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hf;
  logic [7:0]  mf_iq_in = 8'h3c;
  logic        ext_symbol_detect_strobe = 1'b0, ext_burst_abort = 1'b0;
  logic        osc_enable_in = 1'b0, tx_enable_in = 1'b0, rx_enable_in = 1'b0;
  logic        freq_load_strobe = 1'b0, preamble_detect = 1'b0, strobe_on = 1'b0;
  logic        ext_baseband_sample_strobe, tx_symbol_end, pready, pslverr;
  logic [31:0] prdata, rdat;
  logic        baseband_sample_pulse, if_dump_transfer, demod_transfer, burst_abort_pulse;
  logic        counters_active, rx_acquire_mode, rx_enabled, rx_datapath_reset;
  logic        osc_reset, osc_word_loaded, tx_datapath_reset, tx_start, tx_preamble;
  logic        tx_data_phase, rerr;
  logic [7:0]  osc_freq_word, test_output_bus;
  logic [4:0]  mon;
  int          errors = 0, compares = 0;

  assign mon = {tx_start, burst_abort_pulse, demod_transfer, baseband_sample_pulse,
                rx_datapath_reset};

  always #5 pclk = ~pclk;

  srtmc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .ext_baseband_sample_strobe, .ext_symbol_detect_strobe,
    .ext_burst_abort, .osc_enable_in, .tx_enable_in, .rx_enable_in, .freq_load_strobe,
    .preamble_detect, .tx_symbol_end, .mf_iq_in, .baseband_sample_pulse,
    .if_dump_transfer, .demod_transfer, .burst_abort_pulse, .counters_active,
    .rx_acquire_mode, .rx_enabled, .rx_datapath_reset, .osc_reset, .osc_freq_word,
    .osc_word_loaded, .tx_datapath_reset, .tx_start, .tx_preamble, .tx_data_phase,
    .test_output_bus);

  srtmc_host_model u_host (.pclk, .presetn, .strobe_on, .tx_preamble,
    .ext_baseband_sample_strobe, .tx_symbol_end);

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) errors++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rchk(input string what, input logic [5:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, rdat, exp);
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // cycles with one watched output high over a window
  task automatic cnt(input int b, input int cyc, output int n);
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      if (mon[b] === 1'b1) n++;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("divider", 6'h02, 32'h1);
    apb(1'b0, 6'h05, 8'h00);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    wr(6'h38, 8'h01);
    // receiver: pin and bit share control
    rx_enable_in <= 1'b1;
    wr(6'h37, 8'h04);
    rx_enable_in <= 1'b0;
    cnt(0, 20, n);
    chk("rx held by bit", n, 0);
    chk("rx enabled", rx_enabled, 1);
    chk("acquire", rx_acquire_mode, 1);
    wr(6'h37, 8'h00);
    cnt(0, 20, n);
    chk("rx reset cycles", n, 6);
    rchk("test select", 6'h38, 32'h0);
    chk("test bus", test_output_bus, 8'h3c);
    wr(6'h37, 8'h04);
    wr(6'h38, 8'h00);
    // outside sample strobe, then internal divider
    wr(6'h01, 8'h01);
    strobe_on <= 1'b1;
    while (ext_baseband_sample_strobe !== 1'b1) @(posedge pclk);
    n = 0;
    while (baseband_sample_pulse !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk("sample latency", n, 5);
    cnt(1, 80, n);
    chk("ext samples", n, 10);
    strobe_on <= 1'b0;
    wr(6'h01, 8'h00);
    wr(6'h02, 8'h03);
    step(8);
    cnt(1, 40, n);
    chk("div samples", n, 10);
    // manual detect
    ext_symbol_detect_strobe <= 1'b1;
    cnt(2, 40, n);
    chk("detect off", n, 0);
    ext_symbol_detect_strobe <= 1'b0;
    wr(6'h30, 8'h01);
    ext_symbol_detect_strobe <= 1'b1;
    cnt(2, 40, n);
    chk("detect pin", n, 1);
    chk("counters on", counters_active, 1);
    wr(6'h31, 8'h01);
    cnt(2, 40, n);
    chk("detect or held", n, 0);
    ext_symbol_detect_strobe <= 1'b0;
    wr(6'h31, 8'h00);
    wr(6'h31, 8'h01);
    cnt(2, 40, n);
    chk("detect bit", n, 1);
    wr(6'h31, 8'h00);
    // burst abort
    ext_burst_abort <= 1'b1;
    cnt(3, 40, n);
    chk("abort pin", n, 1);
    chk("counters off", counters_active, 0);
    chk("acquire abort", rx_acquire_mode, 1);
    ext_burst_abort <= 1'b0;
    preamble_detect <= 1'b1;
    step(1);
    preamble_detect <= 1'b0;
    step(2);
    chk("counters back", counters_active, 1);
    wr(6'h32, 8'h01);
    cnt(3, 40, n);
    chk("abort bit", n, 1);
    wr(6'h32, 8'h00);
    // oscillator
    wr(6'h10, 8'h5a);
    wr(6'h37, 8'h05);
    freq_load_strobe <= 1'b1;
    step(4);
    freq_load_strobe <= 1'b0;
    step(16);
    chk("freq word", osc_freq_word, 8'h5a);
    osc_enable_in <= 1'b1;
    wr(6'h37, 8'h04);
    step(8);
    chk("osc by pin", osc_reset, 0);
    osc_enable_in <= 1'b0;
    step(8);
    chk("osc reset", osc_reset, 1);
    wr(6'h37, 8'h05);
    step(4);
    chk("word lost", osc_freq_word, 8'h00);
    wr(6'h00, 8'h01);
    step(16);
    chk("word reload", osc_freq_word, 8'h5a);
    wr(6'h00, 8'h00);
    // transmitter
    tx_enable_in <= 1'b1;
    cnt(4, 30, n);
    chk("tx start", n, 1);
    chk("tx data", tx_data_phase, 1);
    tx_enable_in <= 1'b0;
    step(8);
    chk("tx reset", tx_datapath_reset, 1);
    wr(6'h37, 8'h06);
    cnt(4, 20, n);
    chk("tx start bit", n, 1);
    wr(6'h37, 8'h04);
    step(8);
    chk("tx reset bit", tx_datapath_reset, 1);
    report_and_stop();
  end

  // the sequence needs under a thousand clocks
  initial begin
    #200us;
    errors++;
    report_and_stop();
  end
endmodule // srtmc_top_tb_top

`default_nettype wire
